// ---- usp_serial_port.sv ----
// Serial port clocking, frame transmitter and frame receiver
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Down-counter reloads, ticks at zero
// - Bit clock: ticks by 16, 8 or 2
// - Sync select; pin direction picks master/slave
// - Twelve-bit divisor from high and low parts
// - Double speed divides by 8 not 16
// - Double speed ignored in synchronous mode
// - Receiver counts 8 ticks per bit at double speed
// - Slave clock synchronised then edge detected
// - Clock pin input as slave, output as master
// - Sample on edge opposite to data change
// - Polarity zero: change rising, sample falling
// - Five to nine bits, parity, stop options
// - Start, data LSB first, parity, stops
// - Next frame back to back, else idle high
// - One shared format setting for both directions
// - Only first stop bit checked for framing
// - Parity is data xor, inverted when odd
// - Transmit enable takes over transmit pin
// - Sync master with transmit or receive enabled takes over clock pin
// - Buffer loads shifter when idle or frame ends
// - Unused upper data bits ignored
module usp_serial_port (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic [3:0]  i_baud_divisor_high,
	input  wire logic [7:0]  i_baud_divisor_low,
	input  wire logic        i_baud_divisor_low_write,
	input  wire logic        i_double_speed_bit,
	input  wire logic        i_sync_select,
	input  wire logic        i_transfer_clock_direction,
	input  wire logic        i_clock_polarity,
	input  wire logic [2:0]  i_character_size,
	input  wire logic [1:0]  i_parity_mode,
	input  wire logic        i_stop_select,
	input  wire logic        i_transmit_enable_bit,
	input  wire logic        i_receive_enable,
	input  wire logic        i_data_valid,
	output logic             o_data_ready,
	input  wire logic [8:0]  i_data,
	output logic             o_data_empty_flag,
	output logic             o_transmit_complete_flag,
	input  wire logic        i_transmit_complete_clear,
	output logic             o_transmit_pin,
	output logic             o_transmit_override,
	input  wire logic        i_receive_pin,
	input  wire logic        i_transfer_clock_pin,
	output logic             o_transfer_clock_pin,
	output logic             o_transfer_clock_oe_n,
	output logic [8:0]       o_receive_data,
	output logic             o_receive_complete,
	output logic             o_frame_error_flag,
	output logic             o_parity_error
);
	logic                        baud_tick;
	logic [usp_pkg::DIV_W-1:0]   divisor;
	logic                        master;
	logic                        slave;
	logic [4:0]                  async_div;
	logic [3:0]                  nbits;
	logic                        par_en;
	logic                        par_odd;
	logic                        xck_s1_q;
	logic                        xck_s2_q;
	logic                        xck_s3_q;
	logic                        xck_q;
	logic                        rxd_s1_q;
	logic                        rxd_s2_q;
	logic                        xck_rise;
	logic                        xck_fall;
	logic                        sync_change;
	logic                        sync_sample;
	logic [usp_pkg::CNT_W-1:0]   tx_pre_q;
	logic                        tx_pre_wrap;
	logic                        tx_step;
	logic                        fifo_valid;
	logic [8:0]                  fifo_data;
	logic                        load;
	logic                        finish;
	logic [8:0]                  load_word;
	usp_pkg::usp_tx_state_type   tx_state_q;
	logic [8:0]                  tx_shift_q;
	logic [3:0]                  tx_idx_q;
	logic                        tx_par_q;
	logic                        tx_bit_q;
	logic                        tx_done_q;
	usp_pkg::usp_rx_state_type   rx_state_q;
	logic [usp_pkg::CNT_W-1:0]   rx_cnt_q;
	logic                        rx_strobe;
	logic [3:0]                  rx_idx_q;
	logic [8:0]                  rx_shift_q;
	logic                        rx_perr_q;

	// Baud divisor and the tick generator
	assign divisor = {i_baud_divisor_high, i_baud_divisor_low};
	usp_baud_gen u_baud (
		.i_clock   (i_clock),
		.i_rst_n   (i_rst_n),
		.i_divisor (divisor),
		.i_reload  (i_baud_divisor_low_write),
		.o_tick    (baud_tick)
	);

	// Clocking mode and frame format decode, shared by both directions
	assign master    = i_sync_select && i_transfer_clock_direction;
	assign slave     = i_sync_select && !i_transfer_clock_direction;
	assign async_div = i_double_speed_bit ? usp_pkg::DOUBLE_DIV
		: usp_pkg::NORMAL_DIV;
	assign nbits     = usp_pkg::data_bits(i_character_size);
	assign par_en    = i_parity_mode[1];
	assign par_odd   = i_parity_mode[0];

	// Pin synchronisers and a third stage for edge detection
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			xck_s1_q <= 1'b0;
			xck_s2_q <= 1'b0;
			xck_s3_q <= 1'b0;
			rxd_s1_q <= usp_pkg::LINE_IDLE;
			rxd_s2_q <= usp_pkg::LINE_IDLE;
		end
		else
		begin
			xck_s1_q <= i_transfer_clock_pin;
			xck_s2_q <= xck_s1_q;
			xck_s3_q <= xck_s2_q;
			rxd_s1_q <= i_receive_pin;
			rxd_s2_q <= rxd_s1_q;
		end
	end

	// Master clock toggles per tick, so it runs at half the tick rate
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			xck_q <= 1'b0;
		else if (master && baud_tick)
			xck_q <= !xck_q;
		else if (!master)
			xck_q <= i_clock_polarity;
	end

	// Edges of the slave clock seen after synchronising
	assign xck_rise = xck_s2_q && !xck_s3_q;
	assign xck_fall = !xck_s2_q && xck_s3_q;

	// Data change and sample edges from the polarity setting
	assign sync_change = master
		? (baud_tick && (xck_q == i_clock_polarity))
		: (i_clock_polarity ? xck_fall : xck_rise);
	assign sync_sample = master
		? (baud_tick && (xck_q != i_clock_polarity))
		: (i_clock_polarity ? xck_rise : xck_fall);

	// Clock pin is driven only as master with a direction enabled
	assign o_transfer_clock_pin  = xck_q;
	assign o_transfer_clock_oe_n = !(master
		&& (i_transmit_enable_bit || i_receive_enable));

	// Asynchronous transmit prescaler over baud ticks
	assign tx_pre_wrap = baud_tick
		&& ({1'b0, tx_pre_q} == async_div - 5'h01);
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			tx_pre_q <= '0;
		else if (i_sync_select || tx_pre_wrap)
			tx_pre_q <= '0;
		else if (baud_tick)
			tx_pre_q <= tx_pre_q + 4'h1;
	end
	assign tx_step = i_sync_select ? sync_change : tx_pre_wrap;

	// Transmit buffer between the data port and the shifter
	usp_fifo #(
		.WIDTH (usp_pkg::DATA_W),
		.DEPTH (usp_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clock    (i_clock),
		.i_rst_n    (i_rst_n),
		.i_wr_valid (i_data_valid),
		.o_wr_ready (o_data_ready),
		.i_wr_data  (i_data),
		.o_rd_valid (fifo_valid),
		.i_rd_ready (load),
		.o_rd_data  (fifo_data)
	);
	assign o_data_empty_flag = !fifo_valid;

	// Frame end and shifter load decisions
	assign finish = tx_step && ((tx_state_q == usp_pkg::TX_STOP2)
		|| (tx_state_q == usp_pkg::TX_STOP1 && !i_stop_select));
	assign load = fifo_valid && (finish || (tx_step
		&& tx_state_q == usp_pkg::TX_IDLE
		&& i_transmit_enable_bit));
	assign load_word = usp_pkg::mask_data(fifo_data,
		i_character_size);

	// Transmitter state machine, one step per bit clock
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_state_q <= usp_pkg::TX_IDLE;
			tx_shift_q <= usp_pkg::DATA_RESET;
			tx_idx_q   <= 4'h0;
			tx_par_q   <= 1'b0;
			tx_bit_q   <= usp_pkg::LINE_IDLE;
		end
		else if (load)
		begin
			tx_state_q <= usp_pkg::TX_START;
			tx_shift_q <= load_word;
			tx_par_q   <= usp_pkg::parity_of(load_word, par_odd);
			tx_idx_q   <= 4'h0;
			tx_bit_q   <= 1'b0;
		end
		else if (tx_step)
		begin
			case (tx_state_q)
				usp_pkg::TX_IDLE:
					tx_bit_q <= usp_pkg::LINE_IDLE;
				usp_pkg::TX_START, usp_pkg::TX_DATA:
				begin
					if (tx_idx_q == nbits)
					begin
						tx_bit_q   <= par_en ? tx_par_q : 1'b1;
						tx_state_q <= par_en ? usp_pkg::TX_PARITY
							: usp_pkg::TX_STOP1;
					end
					else
					begin
						tx_bit_q   <= tx_shift_q[0];
						tx_shift_q <= tx_shift_q >> 1;
						tx_idx_q   <= tx_idx_q + 4'h1;
						tx_state_q <= usp_pkg::TX_DATA;
					end
				end
				usp_pkg::TX_PARITY:
				begin
					tx_bit_q   <= 1'b1;
					tx_state_q <= usp_pkg::TX_STOP1;
				end
				usp_pkg::TX_STOP1:
					tx_state_q <= i_stop_select ? usp_pkg::TX_STOP2
						: usp_pkg::TX_IDLE;
				usp_pkg::TX_STOP2:
					tx_state_q <= usp_pkg::TX_IDLE;
				default:
					tx_state_q <= usp_pkg::TX_IDLE;
			endcase
		end
	end

	// Complete flag: set on a frame end with nothing queued, set wins
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			tx_done_q <= 1'b0;
		else if (finish && !fifo_valid)
			tx_done_q <= 1'b1;
		else if (i_transmit_complete_clear)
			tx_done_q <= 1'b0;
	end
	assign o_transmit_complete_flag = tx_done_q;

	// Pin override holds until pending frames are out
	assign o_transmit_pin      = tx_bit_q;
	assign o_transmit_override = i_transmit_enable_bit || fifo_valid
		|| (tx_state_q != usp_pkg::TX_IDLE);

	// Receiver sample counter, 16 or 8 ticks per bit, middle sample
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rx_cnt_q <= '0;
		else if (rx_state_q == usp_pkg::RX_IDLE)
			rx_cnt_q <= '0;
		else if (baud_tick)
			rx_cnt_q <= ({1'b0, rx_cnt_q} == async_div - 5'h01) ? '0
				: rx_cnt_q + 4'h1;
	end
	assign rx_strobe = i_sync_select ? sync_sample
		: (baud_tick && ({1'b0, rx_cnt_q}
		== (async_div >> 1) - 5'h01));

	// Receiver state machine
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_state_q         <= usp_pkg::RX_IDLE;
			rx_idx_q           <= 4'h0;
			rx_shift_q         <= usp_pkg::DATA_RESET;
			rx_perr_q          <= 1'b0;
			o_receive_data     <= usp_pkg::DATA_RESET;
			o_receive_complete <= 1'b0;
			o_frame_error_flag <= 1'b0;
			o_parity_error     <= 1'b0;
		end
		else
		begin
			o_receive_complete <= 1'b0;
			case (rx_state_q)
				usp_pkg::RX_IDLE:
				begin
					rx_idx_q   <= 4'h0;
					rx_shift_q <= usp_pkg::DATA_RESET;
					rx_perr_q  <= 1'b0;
					if (i_receive_enable && !rxd_s2_q
						&& (!i_sync_select || rx_strobe))
						rx_state_q <= i_sync_select ? usp_pkg::RX_DATA
							: usp_pkg::RX_START;
				end
				usp_pkg::RX_START:
					if (rx_strobe)
						rx_state_q <= rxd_s2_q ? usp_pkg::RX_IDLE
							: usp_pkg::RX_DATA;
				usp_pkg::RX_DATA:
					if (rx_strobe)
					begin
						rx_shift_q[rx_idx_q] <= rxd_s2_q;
						rx_idx_q <= rx_idx_q + 4'h1;
						if (rx_idx_q == nbits - 4'h1)
							rx_state_q <= par_en ? usp_pkg::RX_PARITY
								: usp_pkg::RX_STOP;
					end
				usp_pkg::RX_PARITY:
					if (rx_strobe)
					begin
						rx_perr_q  <= rxd_s2_q != usp_pkg::parity_of(
							rx_shift_q, par_odd);
						rx_state_q <= usp_pkg::RX_STOP;
					end
				usp_pkg::RX_STOP:
					if (rx_strobe)
					begin
						o_receive_data     <= rx_shift_q;
						o_receive_complete <= 1'b1;
						o_frame_error_flag <= !rxd_s2_q;
						o_parity_error     <= rx_perr_q;
						rx_state_q         <= usp_pkg::RX_IDLE;
					end
				default:
					rx_state_q <= usp_pkg::RX_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- usp_pkg.sv ----
// Shared constants, types and helpers for the serial port transmitter and receiver
`default_nettype none
package usp_pkg;
	// Widths and buffer depth
	localparam int DIV_W      = 12;
	localparam int DATA_W     = 9;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W      = 4;

	// Baud tick dividers per clocking mode
	localparam logic [4:0] NORMAL_DIV = 5'h10;
	localparam logic [4:0] DOUBLE_DIV = 5'h08;

	// Reset values
	localparam logic [DIV_W-1:0]  DIVISOR_RESET = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RESET    = 9'h000;
	localparam logic              LINE_IDLE     = 1'b1;

	// Character size code for nine data bits, and smallest size
	localparam logic [2:0] SIZE_NINE = 3'h7;
	localparam logic [3:0] BITS_MIN  = 4'h5;
	localparam logic [3:0] BITS_NINE = 4'h9;

	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2
	} usp_tx_state_type;

	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
	} usp_rx_state_type;

	// Number of data bits from the character size code
	function automatic logic [3:0] data_bits(input logic [2:0] size);
		if (size == SIZE_NINE)
			return BITS_NINE;
		return BITS_MIN + {2'h0, size[1:0]};
	endfunction

	// Clear the data bits above the character size
	function automatic logic [DATA_W-1:0] mask_data(
		input logic [DATA_W-1:0] d, input logic [2:0] size);
		logic [DATA_W:0] m;
		m = (10'h001 << data_bits(size)) - 10'h001;
		return d & m[DATA_W-1:0];
	endfunction

	// Even parity is the xor of the data, odd parity its inverse
	function automatic logic parity_of(
		input logic [DATA_W-1:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction
endpackage
`default_nettype wire

// ---- usp_baud_gen.sv ----
// Baud rate generator: reloading down-counter with a tick at zero
`timescale 1ns/1ns
`default_nettype none
module usp_baud_gen (
	input  wire logic                        i_clock,
	input  wire logic                        i_rst_n,
	input  wire logic [usp_pkg::DIV_W-1:0]   i_divisor,
	input  wire logic                        i_reload,
	output logic                             o_tick
);
	logic [usp_pkg::DIV_W-1:0] count_q;
	logic [usp_pkg::DIV_W-1:0] count_d;
	logic                      at_zero;

	// Reload at zero or on a low divisor write, else count down
	assign at_zero = (count_q == '0);
	assign count_d = (at_zero || i_reload) ? i_divisor
		: count_q - 12'h001;
	assign o_tick  = at_zero;

	// Counter register
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			count_q <= usp_pkg::DIVISOR_RESET;
		else
			count_q <= count_d;
	end
endmodule
`default_nettype wire

// ---- usp_fifo.sv ----
// Transmit buffer: shifting FIFO whose head word is a register
`timescale 1ns/1ns
`default_nettype none
module usp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready,
	output logic [WIDTH-1:0]      o_rd_data
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [CW-1:0]    count_q;
	logic [CW-1:0]    slot;
	logic             push;
	logic             pop;

	// Handshakes and write slot after an optional pop
	assign o_wr_ready = (count_q != CW'(DEPTH));
	assign o_rd_valid = (count_q != '0);
	assign push       = i_wr_valid && o_wr_ready;
	assign pop        = i_rd_ready && o_rd_valid;
	assign slot       = pop ? count_q - CW'(1) : count_q;
	assign o_rd_data  = mem_q[0];

	// Word storage shifts toward the head on a pop
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				if (push && slot == CW'(i))
					mem_q[i] <= i_wr_data;
				else if (pop && i < DEPTH - 1)
					mem_q[i] <= mem_q[(i + 1) % DEPTH]; // Stays in range
			end
		end
	end

	// Fill level
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			count_q <= '0;
		else
			count_q <= slot + CW'(push);
	end
endmodule
`default_nettype wire

// ---- usp_serial_port_props.sv ----
// Checker for the serial port clock and transmit ports
`timescale 1ns/1ns
`default_nettype none
module usp_serial_port_props (
	input wire logic       i_clock,
	input wire logic       i_rst_n,
	input wire logic [3:0] i_baud_divisor_high,
	input wire logic [7:0] i_baud_divisor_low,
	input wire logic       i_baud_divisor_low_write,
	input wire logic       i_sync_select,
	input wire logic       i_transfer_clock_direction,
	input wire logic       i_transmit_enable_bit,
	input wire logic       i_receive_enable,
	input wire logic       i_data_valid,
	input wire logic       o_data_ready,
	input wire logic       o_data_empty_flag,
	input wire logic       o_transmit_complete_flag,
	input wire logic       o_transmit_pin,
	input wire logic       o_transmit_override,
	input wire logic       o_transfer_clock_pin,
	input wire logic       o_transfer_clock_oe_n,
	input wire logic       o_receive_complete
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	wire logic        master;
	wire logic        moved;
	wire logic [11:0] divisor;
	logic      [11:0] gap_q;
	logic             seen_q;
	logic             clk_q;
	// Master mode decode and clock toggle detect
	assign master  = i_sync_select & i_transfer_clock_direction;
	assign divisor = {i_baud_divisor_high, i_baud_divisor_low};
	assign moved   = clk_q != o_transfer_clock_pin;
	// Cycles since the last toggle, saturating
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			gap_q  <= 12'h000;
			seen_q <= 1'b0;
			clk_q  <= 1'b0;
		end
		else
		begin
			clk_q  <= o_transfer_clock_pin;
			gap_q  <= moved ? 12'h000 : gap_q + {11'h0, gap_q != 12'hfff};
			seen_q <= master & !i_baud_divisor_low_write & (seen_q | moved);
		end
	end
	chk_clock_gap: assert property (
		master && seen_q && moved |-> gap_q >= divisor)
		else $error("Master clock toggled too soon");
	chk_clock_drive: assert property (
		o_transfer_clock_oe_n ==
		!(master && (i_transmit_enable_bit || i_receive_enable)))
		else $error("Clock pin drive wrong");
	chk_pin_owner: assert property (
		i_transmit_enable_bit |-> o_transmit_override)
		else $error("Transmit pin not taken over");
	chk_idle_high: assert property (
		!o_transmit_override |-> o_transmit_pin)
		else $error("Released line not high");
	chk_empty_ready: assert property (
		o_data_empty_flag |-> o_data_ready)
		else $error("Empty buffer refuses data");
	chk_write_held: assert property (
		i_data_valid && o_data_ready |=> !o_data_empty_flag)
		else $error("Written word lost");
	chk_done_empty: assert property (
		$rose(o_transmit_complete_flag) |-> $past(o_data_empty_flag))
		else $error("Complete with data pending");
	chk_rx_pulse: assert property (
		o_receive_complete |=> !o_receive_complete)
		else $error("Receive pulse too long");
endmodule
bind usp_serial_port usp_serial_port_props i_props (
	.i_clock, .i_rst_n, .i_baud_divisor_high, .i_baud_divisor_low,
	.i_baud_divisor_low_write, .i_sync_select, .i_transfer_clock_direction,
	.i_transmit_enable_bit, .i_receive_enable, .i_data_valid, .o_data_ready,
	.o_data_empty_flag, .o_transmit_complete_flag, .o_transmit_pin,
	.o_transmit_override, .o_transfer_clock_pin, .o_transfer_clock_oe_n,
	.o_receive_complete
);
`default_nettype wire

// ---- usp_remote.sv ----
// Remote serial device that sends frames on the receive line
`timescale 1ns/1ns
`default_nettype none
module usp_remote (
	input  wire logic i_clock,
	output logic      o_line
);
	// Line rests high between frames
	initial o_line = 1'b1;
	// Bits LSB first, one bit period each, then idle
	task automatic send(input logic [12:0] bits, input int len, per);
		@(posedge i_clock);
		for (int i = 0; i < len; i++)
		begin
			o_line <= bits[i];
			repeat (per) @(posedge i_clock);
		end
		o_line <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- usp_serial_port_test.sv ----
// Self-checking bench for the serial port block
`timescale 1ns/1ns
`default_nettype none
module usp_serial_port_test;
	localparam int TICK  = 3;
	localparam int LIMIT = 80000;
	logic        i_clock, i_rst_n, i_baud_divisor_low_write;
	logic        i_double_speed_bit, i_sync_select, i_clock_polarity;
	logic        i_transfer_clock_direction, i_stop_select, i_data_valid;
	logic        i_transmit_enable_bit, i_receive_enable;
	logic        i_transmit_complete_clear, i_transfer_clock_pin;
	wire logic   i_receive_pin;
	logic [3:0]  i_baud_divisor_high;
	logic [7:0]  i_baud_divisor_low;
	logic [2:0]  i_character_size;
	logic [1:0]  i_parity_mode;
	logic [8:0]  i_data, o_receive_data;
	logic        o_data_ready, o_data_empty_flag, o_transmit_complete_flag;
	logic        o_transmit_pin, o_transmit_override, o_transfer_clock_pin;
	logic        o_transfer_clock_oe_n, o_receive_complete;
	logic        o_frame_error_flag, o_parity_error;
	logic        sync_chk, tx_prev, clk_prev;
	logic [12:0] f;
	int          num_errors, total_checks, cyc, k, n, p, s, per, t0, t1;

	usp_serial_port i_dut (
		.i_clock, .i_rst_n, .i_baud_divisor_high, .i_baud_divisor_low,
		.i_baud_divisor_low_write, .i_double_speed_bit, .i_sync_select,
		.i_transfer_clock_direction, .i_clock_polarity, .i_character_size,
		.i_parity_mode, .i_stop_select, .i_transmit_enable_bit,
		.i_receive_enable, .i_data_valid, .o_data_ready, .i_data,
		.o_data_empty_flag, .o_transmit_complete_flag,
		.i_transmit_complete_clear, .o_transmit_pin, .o_transmit_override,
		.i_receive_pin, .i_transfer_clock_pin, .o_transfer_clock_pin,
		.o_transfer_clock_oe_n, .o_receive_data, .o_receive_complete,
		.o_frame_error_flag, .o_parity_error
	);
	usp_remote i_remote (.i_clock, .o_line(i_receive_pin));

	// Clock source
	initial
	begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// Cycle count with a ceiling against hangs
	always @(posedge i_clock)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			num_errors++;
			finish_test();
		end
	end
	// Synchronous data may change only where the clock moves
	always @(negedge i_clock)
	begin
		if (sync_chk && o_transmit_pin !== tx_prev)
			cmp("change edge",
				9'({i_clock_polarity, ~i_clock_polarity}),
				9'({clk_prev, o_transfer_clock_pin}));
		tx_prev = o_transmit_pin;
		clk_prev = o_transfer_clock_pin;
	end

	task automatic cmp(input string what, input logic [8:0] exp, got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Expected frame: start, data LSB first, parity, stops high
	function automatic logic [12:0] frm(input logic [8:0] d, input int nb, pm);
		logic [12:0] r;
		logic        q;
		r = '1;
		r[0] = 1'b0;
		q = pm[0];
		for (int i = 0; i < nb; i++)
		begin
			r[i+1] = d[i];
			q ^= d[i];
		end
		if (pm[1])
			r[nb+1] = q;
		return r;
	endfunction
	task automatic cfg(input int nb, pm, sb, db);
		@(posedge i_clock);
		i_character_size <= (nb == 9) ? 3'h7 : 3'(nb - 5);
		i_parity_mode <= 2'(pm);
		i_stop_select <= 1'(sb);
		i_double_speed_bit <= 1'(db);
		n = nb;
		p = pm;
		s = sb;
		per = (db != 0 ? 8 : 16) * TICK;
	endtask
	task automatic push(input logic [8:0] d);
		@(posedge i_clock);
		i_data_valid <= 1'b1;
		i_data <= d;
		do @(negedge i_clock); while (o_data_ready !== 1'b1);
		@(posedge i_clock);
		i_data_valid <= 1'b0;
	endtask
	task automatic clr;
		@(posedge i_clock);
		i_transmit_complete_clear <= 1'b1;
		@(posedge i_clock);
		i_transmit_complete_clear <= 1'b0;
		@(negedge i_clock);
		cmp("flag cleared", 9'h0, {8'h0, o_transmit_complete_flag});
	endtask
	task automatic wait_clk(input logic v);
		k = 0;
		while (o_transfer_clock_pin !== v && k < 100)
		begin
			@(negedge i_clock);
			k++;
		end
	endtask
	// Decode one frame off the transmit pin at mid-bit
	task automatic tx_frame(input logic [8:0] d);
		f = frm(d, n, p);
		k = 0;
		@(negedge i_clock);
		while (o_transmit_pin !== 1'b0 && k < 5000)
		begin
			@(negedge i_clock);
			k++;
		end
		t0 = cyc;
		repeat (per / 2) @(negedge i_clock);
		for (int i = 0; i < 2 + n + p / 2 + s; i++)
		begin
			cmp("serial bit", 9'(f[i]), 9'(o_transmit_pin));
			if (i < 1 + n + p / 2 + s)
				repeat (per) @(negedge i_clock);
		end
	endtask

	initial
	begin
		i_rst_n = 1'b0;
		{i_double_speed_bit, i_sync_select, i_clock_polarity} = 3'h0;
		{i_stop_select, i_data_valid, i_transmit_enable_bit} = 3'h0;
		{i_transfer_clock_direction, i_transmit_complete_clear} = 2'h0;
		{i_baud_divisor_low_write, i_transfer_clock_pin} = 2'h0;
		{i_receive_enable, sync_chk} = 2'h2;
		i_baud_divisor_high = 4'h0;
		i_baud_divisor_low = 8'(TICK - 1);
		i_character_size = 3'h3;
		i_parity_mode = 2'h0;
		i_data = 9'h000;
		repeat (20) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(negedge i_clock);
		cmp("idle line", 9'h1, 9'(o_transmit_pin));
		cmp("buffer flags", 9'h3, 9'({o_data_ready, o_data_empty_flag}));
		@(posedge i_clock);
		i_baud_divisor_low_write <= 1'b1;
		@(posedge i_clock);
		i_baud_divisor_low_write <= 1'b0;
		// Fill the buffer while the transmitter is off
		cfg(8, 0, 0, 0);
		for (int j = 0; j < 8; j++)
			push(9'h1A5 + 9'(j * 37));
		@(negedge i_clock);
		cmp("full buffer", 9'h0, 9'({o_data_ready, o_data_empty_flag}));
		// Pending words keep the pin owned, line still idle high
		cmp("held line", 9'h3, 9'({o_transmit_override, o_transmit_pin}));
		@(posedge i_clock);
		i_transmit_enable_bit <= 1'b1;
		// Drain: frames in order and without gaps
		for (int j = 0; j < 8; j++)
		begin
			t1 = t0;
			tx_frame(9'h1A5 + 9'(j * 37));
			if (j > 0)
				cmp("frame gap", 9'h0, 9'(t0 - t1 - 10 * per));
		end
		repeat (per) @(negedge i_clock);
		cmp("all sent", 9'h3,
			9'({o_data_empty_flag, o_transmit_complete_flag}));
		// Every frame format, double speed with two stops
		for (int j = 0; j < 30; j++)
		begin
			cfg(j % 5 == 4 ? 9 : 5 + j % 5, (j / 5) % 3 == 0 ? 0 : (j / 5) % 3 + 1,
				j / 15, j / 15);
			clr();
			push(9'h1A5 ^ 9'(j));
			tx_frame(9'h1A5 ^ 9'(j));
			repeat (per) @(negedge i_clock);
			cmp("frame done", 9'h1, 9'(o_transmit_complete_flag));
		end
		// Reception: clean, parity, first stop, second stop, double
		for (int j = 0; j < 5; j++)
		begin
			cfg(8, 2, 1, j == 4);
			f = frm(9'h0C3 + 9'(j), 8, 2);
			f[9] = f[9] ^ (j == 1);
			f[10] = f[10] & (j != 2);
			f[11] = f[11] & (j != 3);
			fork
				i_remote.send(f, 12, per);
				begin
					k = 0;
					do
					begin
						@(negedge i_clock);
						k++;
					end
					while (o_receive_complete !== 1'b1 && k < 2000);
					cmp("rx data", 9'h0C3 + 9'(j), o_receive_data);
					cmp("rx parity", 9'(j == 1), 9'(o_parity_error));
					cmp("rx framing", 9'(j == 2), 9'(o_frame_error_flag));
				end
			join
			repeat (per * 14) @(negedge i_clock);
		end
		// Synchronous master, both polarities
		for (int j = 0; j < 2; j++)
		begin
			@(posedge i_clock);
			i_sync_select <= 1'b0;
			i_clock_polarity <= 1'(j);
			cfg(8, 0, 0, j);
			@(posedge i_clock);
			i_sync_select <= 1'b1;
			i_transfer_clock_direction <= 1'b1;
			repeat (4) @(negedge i_clock);
			cmp("master drive", 9'h0, 9'(o_transfer_clock_oe_n));
			clr();
			sync_chk = 1'b1;
			push(9'h05A);
			wait_clk(1'b0);
			wait_clk(1'b1);
			wait_clk(1'b0);
			t1 = k;
			wait_clk(1'b1);
			cmp("clock period", 9'(2 * TICK), 9'(t1 + k));
			repeat (100) @(negedge i_clock);
			sync_chk = 1'b0;
			cmp("master frame", 9'h1, 9'(o_transmit_complete_flag));
		end
		// Synchronous slave clocked from outside
		@(posedge i_clock);
		i_transfer_clock_direction <= 1'b0;
		i_clock_polarity <= 1'b0;
		@(negedge i_clock);
		cmp("slave drive", 9'h1, 9'(o_transfer_clock_oe_n));
		clr();
		push(9'h033);
		repeat (48)
		begin
			repeat (5) @(posedge i_clock);
			i_transfer_clock_pin <= ~i_transfer_clock_pin;
		end
		@(negedge i_clock);
		cmp("slave frame", 9'h1, 9'(o_transmit_complete_flag));
		finish_test();
	end
endmodule
`default_nettype wire
